// File: hdl/tmr_timer_top.sv
// Timer three control register, flags and counter datapath.
`timescale 1ns/1ps
`default_nettype none

module tmr_timer_top (
	// Clock and reset.
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	// Special function register access.
	input  wire logic [7:0] sfrAddr,
	input  wire logic [3:0] sfrPage,
	input  wire logic       sfrWrEn,
	input  wire logic [7:0] sfrWrData,
	input  wire logic       sfrRdEn,
	output logic      [7:0] sfrRdData,
	// System controls from outside the timer.
	input  wire logic       timerIrqEnable,
	input  wire logic       lowSysclkSelect,
	input  wire logic       highSysclkSelect,
	// Clock and trigger sources.
	input  wire logic       extOscIn,
	input  wire logic       comparatorIn,
	// Interrupt and event outputs.
	output logic            timerIrq,
	output logic            highOverflowPulse,
	output logic            lowOverflowPulse,
	output logic            captureEvent,
	// State views.
	output logic      [7:0] timerThreeControl,
	output logic     [15:0] countValue
);
	import tmr_pkg::*;

	// ****************************************
	// Register decode
	// ****************************************
	function automatic tmr_reg_e regSel(input logic [7:0] addr, input logic [3:0] page);
		tmr_reg_e sel;
		sel = REG_NONE;
		if (page == SFR_PAGE_TIMER) begin
			case (addr)
				ADDR_CTRL:     sel = REG_CTRL;
				ADDR_RLD_LOW:  sel = REG_RLD_LOW;
				ADDR_RLD_HIGH: sel = REG_RLD_HIGH;
				ADDR_CNT_LOW:  sel = REG_CNT_LOW;
				ADDR_CNT_HIGH: sel = REG_CNT_HIGH;
				default:       sel = REG_NONE;
			endcase
		end
		return sel;
	endfunction

	tmr_reg_e   regHit;
	logic       wrCtrl;
	logic       wrRldLow;
	logic       wrRldHigh;
	logic       wrCntLow;
	logic       wrCntHigh;

	assign regHit    = regSel(sfrAddr, sfrPage);
	assign wrCtrl    = sfrWrEn && (regHit == REG_CTRL);
	assign wrRldLow  = sfrWrEn && (regHit == REG_RLD_LOW);
	assign wrRldHigh = sfrWrEn && (regHit == REG_RLD_HIGH);
	assign wrCntLow  = sfrWrEn && (regHit == REG_CNT_LOW);
	assign wrCntHigh = sfrWrEn && (regHit == REG_CNT_HIGH);

	// ****************************************
	// Control register fields
	// ****************************************
	logic       highOvf_r;
	logic       lowOvf_r;
	logic       lowIrqEn_r;
	logic       captureEn_r;
	logic       splitMode_r;
	logic       runCtrl_r;
	logic [1:0] extClkSel_r;
	logic [7:0] ctrlValue;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			lowIrqEn_r  <= 1'b0;
			captureEn_r <= 1'b0;
			splitMode_r <= 1'b0;
			runCtrl_r   <= 1'b0;
			extClkSel_r <= XCLK_RESET;
		end else if (wrCtrl) begin
			lowIrqEn_r  <= sfrWrData[BIT_LOW_IRQ_EN];
			captureEn_r <= sfrWrData[BIT_CAPTURE_EN];
			splitMode_r <= sfrWrData[BIT_SPLIT];
			runCtrl_r   <= sfrWrData[BIT_RUN];
			extClkSel_r <= sfrWrData[BIT_XCLK_HI:BIT_XCLK_LO];
		end
	end

	always_comb begin
		ctrlValue                           = CTRL_RESET;
		ctrlValue[BIT_HIGH_OVF]             = highOvf_r;
		ctrlValue[BIT_LOW_OVF]              = lowOvf_r;
		ctrlValue[BIT_LOW_IRQ_EN]           = lowIrqEn_r;
		ctrlValue[BIT_CAPTURE_EN]           = captureEn_r;
		ctrlValue[BIT_SPLIT]                = splitMode_r;
		ctrlValue[BIT_RUN]                  = runCtrl_r;
		ctrlValue[BIT_XCLK_HI:BIT_XCLK_LO]  = extClkSel_r;
	end

	// ****************************************
	// Tick sources
	// ****************************************
	logic lowTick;
	logic highTick;
	logic captureTick;

	tmr_clk_select clkSelect (
		.core_clk         (core_clk),
		.rst_b            (rst_b),
		.extClockSelect   (extClkSel_r),
		.lowSysclkSelect  (lowSysclkSelect),
		.highSysclkSelect (highSysclkSelect),
		.extOscIn         (extOscIn),
		.comparatorIn     (comparatorIn),
		.lowTick          (lowTick),
		.highTick         (highTick),
		.captureTick      (captureTick)
	);

	// ****************************************
	// Counting and reload
	// ****************************************
	logic [7:0] reloadLow_r;
	logic [7:0] reloadHigh_r;
	logic       incr      [2];
	logic       reloadNow [2];
	logic [7:0] reloadVal [2];
	logic       loadNow   [2];
	logic [7:0] cntByte   [2];
	logic       atMax     [2];
	logic       lowWrap;
	logic       highWrap;
	logic       reloadAllowed;
	logic       captureHit;

	always_comb begin
		if (splitMode_r) begin
			incr[0] = lowTick;
			incr[1] = runCtrl_r && highTick;
		end else begin
			incr[0] = runCtrl_r && lowTick;
			incr[1] = incr[0] && atMax[0];
		end
	end

	assign lowWrap       = incr[0] && atMax[0];
	assign highWrap      = incr[1] && atMax[1];
	assign reloadAllowed = !captureEn_r;
	assign captureHit    = captureEn_r && captureTick;

	// In sixteen-bit mode a low wrap alone just rolls to zero.
	assign reloadNow[0] = reloadAllowed && lowWrap && (splitMode_r || highWrap);
	assign reloadNow[1] = reloadAllowed && highWrap;
	assign reloadVal[0] = reloadLow_r;
	assign reloadVal[1] = reloadHigh_r;
	assign loadNow[0]   = wrCntLow;
	assign loadNow[1]   = wrCntHigh;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : gByte
			tmr_byte_counter byteCounter (
				.core_clk    (core_clk),
				.rst_b       (rst_b),
				.incr        (incr[gi]),
				.reloadNow   (reloadNow[gi]),
				.reloadValue (reloadVal[gi]),
				.loadNow     (loadNow[gi]),
				.loadValue   (sfrWrData),
				.countValue  (cntByte[gi]),
				.atMax       (atMax[gi])
			);
		end
	endgenerate

	// A capture overrides a software write to the reload pair.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reloadLow_r  <= BYTE_RESET;
			reloadHigh_r <= BYTE_RESET;
		end else if (captureHit) begin
			reloadLow_r  <= cntByte[0];
			reloadHigh_r <= cntByte[1];
		end else begin
			if (wrRldLow) begin
				reloadLow_r <= sfrWrData;
			end
			if (wrRldHigh) begin
				reloadHigh_r <= sfrWrData;
			end
		end
	end

	// ****************************************
	// Overflow flags
	// ****************************************
	logic highOvf_nxt;
	logic lowOvf_nxt;
	logic highSet;

	assign highSet = highWrap || captureHit;

	always_comb begin
		highOvf_nxt = highOvf_r;
		lowOvf_nxt  = lowOvf_r;
		if (wrCtrl) begin
			highOvf_nxt = sfrWrData[BIT_HIGH_OVF];
			lowOvf_nxt  = sfrWrData[BIT_LOW_OVF];
		end
		if (highSet) begin
			highOvf_nxt = 1'b1;
		end
		if (lowWrap) begin
			lowOvf_nxt = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			highOvf_r <= 1'b0;
			lowOvf_r  <= 1'b0;
		end else begin
			highOvf_r <= highOvf_nxt;
			lowOvf_r  <= lowOvf_nxt;
		end
	end

	// ****************************************
	// Event pulses
	// ****************************************
	logic highPulse_r;
	logic lowPulse_r;
	logic capturePulse_r;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			highPulse_r    <= 1'b0;
			lowPulse_r     <= 1'b0;
			capturePulse_r <= 1'b0;
		end else begin
			highPulse_r    <= highSet;
			lowPulse_r     <= lowWrap;
			capturePulse_r <= captureHit;
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	logic [7:0] rdData_r;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdData_r <= BYTE_RESET;
		end else if (sfrRdEn) begin
			case (regHit)
				REG_CTRL:     rdData_r <= ctrlValue;
				REG_RLD_LOW:  rdData_r <= reloadLow_r;
				REG_RLD_HIGH: rdData_r <= reloadHigh_r;
				REG_CNT_LOW:  rdData_r <= cntByte[0];
				REG_CNT_HIGH: rdData_r <= cntByte[1];
				default:      rdData_r <= BYTE_RESET;
			endcase
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// The request holds as long as an enabled flag stays set.
	assign timerIrq          = timerIrqEnable && (highOvf_r || (lowIrqEn_r && lowOvf_r));
	assign highOverflowPulse = highPulse_r;
	assign lowOverflowPulse  = lowPulse_r;
	assign captureEvent      = capturePulse_r;
	assign sfrRdData         = rdData_r;
	assign timerThreeControl = ctrlValue;
	assign countValue        = {cntByte[1], cntByte[0]};

endmodule
`default_nettype wire

// File: inc/tmr_pkg.sv
// Constants shared by the timer three control and counter logic.
package tmr_pkg;

	// ****************************************
	// Register addresses on page zero
	// ****************************************
	localparam logic [3:0] SFR_PAGE_TIMER = 4'h0;
	localparam logic [7:0] ADDR_CTRL      = 8'h91;
	localparam logic [7:0] ADDR_RLD_LOW   = 8'h92;
	localparam logic [7:0] ADDR_RLD_HIGH  = 8'h93;
	localparam logic [7:0] ADDR_CNT_LOW   = 8'h94;
	localparam logic [7:0] ADDR_CNT_HIGH  = 8'h95;

	// ****************************************
	// Control register field positions
	// ****************************************
	localparam int BIT_HIGH_OVF   = 7;
	localparam int BIT_LOW_OVF    = 6;
	localparam int BIT_LOW_IRQ_EN = 5;
	localparam int BIT_CAPTURE_EN = 4;
	localparam int BIT_SPLIT      = 3;
	localparam int BIT_RUN        = 2;
	localparam int BIT_XCLK_HI    = 1;
	localparam int BIT_XCLK_LO    = 0;

	// ****************************************
	// Reset values and limits
	// ****************************************
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] BYTE_MAX   = 8'hff;
	localparam logic [7:0] BYTE_ONE   = 8'h01;
	localparam logic [1:0] XCLK_RESET = 2'h0;

	// ****************************************
	// Clock divider counts
	// ****************************************
	localparam logic [3:0] SYS_DIV_LAST  = 4'hb;
	localparam logic [3:0] SYS_DIV_ZERO  = 4'h0;
	localparam logic [3:0] SYS_DIV_STEP  = 4'h1;
	localparam logic [2:0] EXT_DIV_LAST  = 3'h7;
	localparam logic [2:0] EXT_DIV_ZERO  = 3'h0;
	localparam logic [2:0] EXT_DIV_STEP  = 3'h1;

	// ****************************************
	// External clock select encodings
	// ****************************************
	typedef enum logic [1:0] {
		XCLK_SYS_DIV12     = 2'b00,
		XCLK_EXT_DIV8      = 2'b01,
		XCLK_SYS_DIV12_ALT = 2'b10,
		XCLK_COMPARATOR    = 2'b11
	} tmr_xclk_e;

	// ****************************************
	// Register decode result
	// ****************************************
	typedef enum logic [2:0] {
		REG_NONE     = 3'b000,
		REG_CTRL     = 3'b001,
		REG_RLD_LOW  = 3'b010,
		REG_RLD_HIGH = 3'b011,
		REG_CNT_LOW  = 3'b100,
		REG_CNT_HIGH = 3'b101
	} tmr_reg_e;

endpackage

// File: hdl/tmr_byte_counter.sv
// One eight-bit count byte with software load and auto-reload.
`timescale 1ns/1ps
`default_nettype none

module tmr_byte_counter (
	// Clock and reset.
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	// Counting control.
	input  wire logic       incr,
	input  wire logic       reloadNow,
	input  wire logic [7:0] reloadValue,
	// Software write.
	input  wire logic       loadNow,
	input  wire logic [7:0] loadValue,
	// Count state.
	output logic      [7:0] countValue,
	output logic            atMax
);
	import tmr_pkg::*;

	logic [7:0] count_r;

	// A software write wins over counting in the same cycle.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			count_r <= BYTE_RESET;
		end else if (loadNow) begin
			count_r <= loadValue;
		end else if (reloadNow) begin
			count_r <= reloadValue;
		end else if (incr) begin
			count_r <= 8'(count_r + BYTE_ONE);
		end
	end

	assign countValue = count_r;
	assign atMax      = (count_r == BYTE_MAX);

endmodule
`default_nettype wire

// File: hdl/tmr_clk_select.sv
// Count tick and capture trigger generation for timer three.
`timescale 1ns/1ps
`default_nettype none

module tmr_clk_select (
	// Clock and reset.
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	// Source selection.
	input  wire logic [1:0] extClockSelect,
	input  wire logic       lowSysclkSelect,
	input  wire logic       highSysclkSelect,
	// Raw sources, synchronous to core_clk.
	input  wire logic       extOscIn,
	input  wire logic       comparatorIn,
	// Ticks.
	output logic            lowTick,
	output logic            highTick,
	output logic            captureTick
);
	import tmr_pkg::*;

	logic [3:0] sysDiv_r;
	logic [2:0] extDiv_r;
	logic       extOscPrev_r;
	logic       compPrev_r;
	logic       sysDiv12Tick;
	logic       extRise;
	logic       extDiv8Tick;
	logic       compRise;
	logic       externalTick;

	// ****************************************
	// Dividers and edge detectors
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sysDiv_r <= SYS_DIV_ZERO;
		end else if (sysDiv_r == SYS_DIV_LAST) begin
			sysDiv_r <= SYS_DIV_ZERO;
		end else begin
			sysDiv_r <= 4'(sysDiv_r + SYS_DIV_STEP);
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			extOscPrev_r <= 1'b0;
			compPrev_r   <= 1'b0;
		end else begin
			extOscPrev_r <= extOscIn;
			compPrev_r   <= comparatorIn;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			extDiv_r <= EXT_DIV_ZERO;
		end else if (extRise) begin
			extDiv_r <= 3'(extDiv_r + EXT_DIV_STEP);
		end
	end

	assign sysDiv12Tick = (sysDiv_r == SYS_DIV_LAST);
	assign extRise      = extOscIn && !extOscPrev_r;
	assign extDiv8Tick  = extRise && (extDiv_r == EXT_DIV_LAST);
	assign compRise     = comparatorIn && !compPrev_r;

	// ****************************************
	// Source multiplexers
	// ****************************************
	always_comb begin
		case (tmr_xclk_e'(extClockSelect))
			XCLK_SYS_DIV12:     externalTick = sysDiv12Tick;
			XCLK_EXT_DIV8:      externalTick = extDiv8Tick;
			XCLK_SYS_DIV12_ALT: externalTick = sysDiv12Tick;
			XCLK_COMPARATOR:    externalTick = compRise;
			default:            externalTick = sysDiv12Tick;
		endcase
	end

	// Capture follows the comparator for 00 and 10, else the divided oscillator.
	assign captureTick = extClockSelect[0] ? extDiv8Tick : compRise;
	assign lowTick     = lowSysclkSelect ? 1'b1 : externalTick;
	assign highTick    = highSysclkSelect ? 1'b1 : externalTick;

endmodule
`default_nettype wire

// File: verification/tmr_cpu_model.sv
// Processor core model that issues special function register accesses.
`timescale 1ns/1ps
`default_nettype none

module tmr_cpu_model (
	// Clock.
	input  wire logic       core_clk,
	// Register access.
	output logic      [7:0] sfrAddr,
	output logic      [3:0] sfrPage,
	output logic            sfrWrEn,
	output logic      [7:0] sfrWrData,
	output logic            sfrRdEn,
	input  wire logic [7:0] sfrRdData
);
	initial begin
		sfrAddr = 8'h00;
		sfrPage = 4'h0;
		sfrWrEn = 1'b0;
		sfrWrData = 8'h00;
		sfrRdEn = 1'b0;
	end

	// Idle address and data show the inverse so no stale value looks valid.
	task automatic write(input logic [3:0] p, input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		sfrPage <= p;
		sfrAddr <= a;
		sfrWrData <= d;
		sfrWrEn <= 1'b1;
		@(posedge core_clk);
		sfrWrEn <= 1'b0;
		sfrAddr <= ~a;
		sfrWrData <= ~d;
	endtask

	task automatic read(input logic [3:0] p, input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		sfrPage <= p;
		sfrAddr <= a;
		sfrRdEn <= 1'b1;
		@(posedge core_clk);
		sfrRdEn <= 1'b0;
		sfrAddr <= ~a;
		@(posedge core_clk);
		d = sfrRdData;
	endtask
endmodule

`default_nettype wire

// File: verification/tmr_timer_top_sva.sv
// Concurrent checks on the timer three control block ports.
`timescale 1ns/1ps
`default_nettype none

module tmr_timer_top_sva
	import tmr_pkg::*;
(
	// Clock and reset.
	input wire logic        core_clk,
	input wire logic        rst_b,
	// Register access.
	input wire logic [7:0]  sfrAddr,
	input wire logic [3:0]  sfrPage,
	input wire logic        sfrWrEn,
	input wire logic [7:0]  sfrWrData,
	input wire logic        sfrRdEn,
	input wire logic [7:0]  sfrRdData,
	// Controls and sources.
	input wire logic        timerIrqEnable,
	input wire logic        lowSysclkSelect,
	input wire logic        highSysclkSelect,
	// Outputs watched.
	input wire logic        timerIrq,
	input wire logic        highOverflowPulse,
	input wire logic        lowOverflowPulse,
	input wire logic        captureEvent,
	input wire logic [7:0]  timerThreeControl,
	input wire logic [15:0] countValue
);
	logic ctrlWr;
	logic cntWr;
	logic [7:0] ctl;

	assign ctl = timerThreeControl;
	assign ctrlWr = sfrWrEn && sfrPage == SFR_PAGE_TIMER && sfrAddr == ADDR_CTRL;
	assign cntWr = sfrWrEn && (sfrAddr == ADDR_CNT_LOW || sfrAddr == ADDR_CNT_HIGH);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	AST_WRAP16: assert property (ctl[4:2] == 3'b001 && lowSysclkSelect && countValue == 16'hffff && !cntWr
		|=> ctl[7:6] == 2'b11 && highOverflowPulse && lowOverflowPulse) else $error("16-bit wrap not flagged");
	AST_SPLIT_WRAP: assert property (ctl[4:3] == 2'b01 && lowSysclkSelect && countValue[7:0] == 8'hff && !cntWr
		|=> ctl[6] && lowOverflowPulse) else $error("split low wrap not flagged");
	AST_SPLIT_HIGH: assert property (ctl[4:2] == 3'b011 && highSysclkSelect && countValue[15:8] == 8'hff && !cntWr
		|=> ctl[7] && highOverflowPulse) else $error("split high wrap not flagged");
	AST_SPLIT_LOW: assert property (ctl[4:2] == 3'b010 && lowSysclkSelect && !cntWr && countValue[7:0] != 8'hff
		|=> countValue[7:0] == $past(countValue[7:0]) + 8'h01 && $stable(countValue[15:8])) else $error("split count wrong");
	AST_STOPPED16: assert property (ctl[3:2] == 2'b00 && !cntWr |=> $stable(countValue)) else $error("stopped count moved");
	AST_IRQ: assert property (timerIrq == (timerIrqEnable && (ctl[7] || (ctl[5] && ctl[6])))) else $error("irq level wrong");
	AST_STICKY: assert property (ctl[7:6] != 2'b00 && !ctrlWr |=> (ctl[7:6] & $past(ctl[7:6])) == $past(ctl[7:6]))
		else $error("flag cleared by hardware");
	AST_CTRL_WRITE: assert property (ctrlWr |=> ctl[5:0] == $past(sfrWrData[5:0])
		&& (ctl[7:6] | ~$past(sfrWrData[7:6])) == 2'b11) else $error("control write lost");
	AST_READ: assert property (sfrRdEn && sfrPage == SFR_PAGE_TIMER && sfrAddr == ADDR_CTRL
		|=> sfrRdData == $past(ctl)) else $error("control read wrong");
	AST_UNMAPPED: assert property (sfrRdEn && sfrPage != SFR_PAGE_TIMER |=> sfrRdData == 8'h00) else $error("bad page read");
	AST_CAPTURE: assert property (captureEvent |-> $past(ctl[4]) && ctl[7])
		else $error("capture flag wrong");

	cover property (highOverflowPulse && lowOverflowPulse);
	cover property (captureEvent);
	cover property (lowOverflowPulse && ctl[3]);
	cover property (highOverflowPulse && ctl[3]);
endmodule

bind tmr_timer_top tmr_timer_top_sva i_tmr_timer_top_sva (.core_clk(core_clk), .rst_b(rst_b), .sfrAddr(sfrAddr),
	.sfrPage(sfrPage), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
	.timerIrqEnable(timerIrqEnable), .lowSysclkSelect(lowSysclkSelect), .highSysclkSelect(highSysclkSelect),
	.timerIrq(timerIrq),
	.highOverflowPulse(highOverflowPulse), .lowOverflowPulse(lowOverflowPulse), .captureEvent(captureEvent),
	.timerThreeControl(timerThreeControl), .countValue(countValue));

`default_nettype wire

// File: verification/tb_top.sv
// Self-checking testbench for the timer three control block.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import tmr_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        timerIrqEnable = 1'b0;
	logic        lowSysclkSelect = 1'b0;
	logic        comparatorIn = 1'b0;
	logic        highSysclkSelect = 1'b0;
	logic        extOscIn = 1'b0;
	logic [7:0]  sfrAddr, sfrWrData, sfrRdData, timerThreeControl, rd;
	logic [3:0]  sfrPage;
	logic        sfrWrEn, sfrRdEn, timerIrq, captureEvent, highOverflowPulse, lowOverflowPulse;
	logic [15:0] countValue;
	logic [7:0]  pat [5] = '{8'h5a, 8'ha5, 8'h3c, 8'h03, 8'h00};
	int          num_errors = 0;
	int          comparisons = 0;

	always #5 core_clk = ~core_clk;

	tmr_cpu_model i_tmr_cpu_model (.core_clk(core_clk), .sfrAddr(sfrAddr), .sfrPage(sfrPage), .sfrWrEn(sfrWrEn),
		.sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData));
	tmr_timer_top i_tmr_timer_top (.core_clk(core_clk), .rst_b(rst_b), .sfrAddr(sfrAddr), .sfrPage(sfrPage),
		.sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
		.timerIrqEnable(timerIrqEnable), .lowSysclkSelect(lowSysclkSelect),
		.highSysclkSelect(highSysclkSelect), .extOscIn(extOscIn), .comparatorIn(comparatorIn),
		.timerIrq(timerIrq), .highOverflowPulse(highOverflowPulse),
		.lowOverflowPulse(lowOverflowPulse), .captureEvent(captureEvent), .timerThreeControl(timerThreeControl),
		.countValue(countValue));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_tmr_cpu_model.write(SFR_PAGE_TIMER, a, d);
	endtask

	task automatic rdchk(input logic [3:0] p, input logic [7:0] a, input logic [7:0] e);
		i_tmr_cpu_model.read(p, a, rd);
		check({8'h00, rd}, {8'h00, e});
	endtask

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		#20000;
		num_errors++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		end_of_test();
	end

	initial begin
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
		rdchk(SFR_PAGE_TIMER, ADDR_CTRL, CTRL_RESET);
		foreach (pat[i]) begin
			wr(ADDR_CTRL, pat[i]);
			rdchk(SFR_PAGE_TIMER, ADDR_CTRL, pat[i]);
		end
		$display("Test control access done");
		i_tmr_cpu_model.write(4'h1, ADDR_CTRL, 8'hff);
		rdchk(SFR_PAGE_TIMER, ADDR_CTRL, 8'h00);
		rdchk(4'h1, ADDR_CTRL, 8'h00);
		rdchk(SFR_PAGE_TIMER, 8'h96, 8'h00);
		$display("Test unmapped access done");
		// Sixteen-bit wrap lands on the same edge as a software flag clear.
		lowSysclkSelect <= 1'b1;
		timerIrqEnable <= 1'b1;
		wr(ADDR_CNT_HIGH, 8'hff);
		wr(ADDR_CNT_LOW, 8'hfd);
		wr(ADDR_RLD_HIGH, 8'h12);
		wr(ADDR_RLD_LOW, 8'h34);
		wr(ADDR_CTRL, 8'h04);
		@(posedge core_clk);
		wr(ADDR_CTRL, 8'h04);
		#1;
		check(countValue, 16'h1234);
		check({15'h0000, timerIrq}, 16'h0001);
		check({14'h0000, highOverflowPulse, lowOverflowPulse}, 16'h0003);
		rdchk(SFR_PAGE_TIMER, ADDR_CTRL, 8'hc4);
		rdchk(SFR_PAGE_TIMER, ADDR_CTRL, 8'hc4);
		wr(ADDR_CTRL, 8'h00);
		rdchk(SFR_PAGE_TIMER, ADDR_CTRL, 8'h00);
		$display("Test sixteen-bit wrap done");
		// Split mode with the high byte stopped.
		wr(ADDR_CNT_HIGH, 8'h10);
		wr(ADDR_CNT_LOW, 8'hfe);
		wr(ADDR_RLD_LOW, 8'h80);
		wr(ADDR_CTRL, 8'h28);
		repeat (4) @(posedge core_clk);
		#1;
		check(countValue, 16'h1082);
		check({15'h0000, timerIrq}, 16'h0001);
		rdchk(SFR_PAGE_TIMER, ADDR_CTRL, 8'h68);
		timerIrqEnable <= 1'b0;
		@(posedge core_clk);
		#1;
		check({15'h0000, timerIrq}, 16'h0000);
		$display("Test split mode done");
		// Split mode high byte wrap with the high byte on the system clock.
		wr(ADDR_CNT_HIGH, 8'hff);
		highSysclkSelect <= 1'b1;
		wr(ADDR_RLD_HIGH, 8'h55);
		wr(ADDR_CTRL, 8'h0c);
		@(posedge core_clk);
		#1;
		check({8'h00, countValue[15:8]}, 16'h0055);
		check({15'h0000, highOverflowPulse}, 16'h0001);
		rdchk(SFR_PAGE_TIMER, ADDR_CTRL, 8'h8c);
		$display("Test split high wrap done");
		// Capture on a comparator rising edge while stopped.
		wr(ADDR_CTRL, 8'h10);
		wr(ADDR_CNT_HIGH, 8'hab);
		wr(ADDR_CNT_LOW, 8'hcd);
		comparatorIn <= 1'b1;
		@(posedge core_clk);
		#1;
		check({15'h0000, captureEvent}, 16'h0001);
		repeat (3) @(posedge core_clk);
		comparatorIn <= 1'b0;
		rdchk(SFR_PAGE_TIMER, ADDR_RLD_LOW, 8'hcd);
		rdchk(SFR_PAGE_TIMER, ADDR_RLD_HIGH, 8'hab);
		rdchk(SFR_PAGE_TIMER, ADDR_CTRL, 8'h90);
		$display("Test capture done");
		// Capture on the eighth oscillator rising edge, none before it.
		wr(ADDR_CTRL, 8'h11);
		wr(ADDR_CNT_LOW, 8'h77);
		repeat (7) begin
			extOscIn <= 1'b1;
			@(posedge core_clk);
			extOscIn <= 1'b0;
			@(posedge core_clk);
		end
		rdchk(SFR_PAGE_TIMER, ADDR_CTRL, 8'h11);
		extOscIn <= 1'b1;
		@(posedge core_clk);
		extOscIn <= 1'b0;
		rdchk(SFR_PAGE_TIMER, ADDR_RLD_LOW, 8'h77);
		rdchk(SFR_PAGE_TIMER, ADDR_CTRL, 8'h91);
		$display("Test oscillator capture done");
		end_of_test();
	end
endmodule

`default_nettype wire
